// ===== rtl/conv_ctrl_pkg.sv
// Constants and types for the 8-bit converter control block
package conv_ctrl_pkg;
    localparam logic [7:0] ADDR_INPUT_PAIR_CONFIG = 8'hba;
    localparam logic [7:0] ADDR_CHANNEL_SELECT    = 8'hbb;
    localparam logic [7:0] ADDR_CONVERTER_CONFIG  = 8'hbc;
    localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'hf8;
    localparam logic [7:0] ADDR_WINDOW_GREATER    = 8'hc4;
    localparam logic [7:0] ADDR_WINDOW_LESS       = 8'hc6;
    localparam logic [7:0] ADDR_DATA_WORD         = 8'hbe;

    localparam logic [3:0] RST_INPUT_PAIR_CONFIG  = 4'h0;
    localparam logic [2:0] RST_CHANNEL_SELECT     = 3'h0;
    localparam logic [4:0] RST_SAR_DIVIDER        = 5'h1f;
    localparam logic [1:0] RST_GAIN               = 2'h0;
    localparam logic [7:0] RST_CONVERTER_CONTROL  = 8'h00;
    localparam logic [7:0] RST_WINDOW_GREATER     = 8'hff;
    localparam logic [7:0] RST_WINDOW_LESS        = 8'h00;
    localparam logic [7:0] RST_DATA_WORD          = 8'h00;

    // Control register field positions
    localparam int CTL_ENABLE = 7;
    localparam int CTL_TRACK  = 6;
    localparam int CTL_DONE   = 5;
    localparam int CTL_BUSY   = 4;
    localparam int CTL_MODE   = 1;
    localparam int CTL_WINDOW = 0;
    // Config register field positions
    localparam int CFG_DIV    = 3;
    localparam int CFG_GAIN   = 0;

    localparam logic [2:0] MODE_SOFTWARE = 3'h0;
    localparam logic [2:0] MODE_TIMER3   = 3'h1;
    localparam logic [2:0] MODE_EXTERNAL = 3'h2;
    localparam logic [2:0] MODE_TIMER2   = 3'h3;

    localparam logic [1:0] TRACK_SAR_CLOCKS   = 2'h3;
    localparam logic [3:0] CONVERT_SAR_CLOCKS = 4'h8;

    typedef struct packed {
        logic       valid;
        logic [2:0] pos_pin;
        logic [2:0] neg_pin;
        logic       differential;
    } mux_sel_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;
endpackage

// ===== rtl/conv_ctrl.sv
// Converter control: pin pairing, channel mux, SAR divider, triggers, flags
//
// Contract
// - Pair bit zero: two single-ended pins; one: even positive, odd negative.
// - Unused bits of pairing, channel and config bit 2 read zero, ignore writes.
// - Differential channel gives two's complement result; single-ended unsigned.
// - Three-bit channel code n selects pin n single-ended when pair clear.
// - Paired: even code even-positive, odd code reversed polarity; others unaffected.
// - SAR clock is system clock divided by divider field plus one.
// - Gain codes 00,01,10,11 select gains 0.5, 1, 2, 4.
// - Enable zero means shutdown; one means active and accepting starts.
// - Normal track mode, enabled: track continuously except while converting.
// - Done flag set on busy falling edge; only software clears it.
// - Busy reads one while converting; write one starts only in mode 000.
// - Start mode picks trigger: software, timer 3, external, timer 2, companion.
// - Low-power track, internal trigger: three SAR clocks tracking, then convert.
// - Low-power track, external mode: track while start low, convert on rise.
// - Window flag set when result meets window; software clears it.
// - Own start pin used when routed, else companion start pin.
// - Busy falling edge raises interrupt request if enabled; result lands in data word.
// - Result compared to greater and less limits; limit order picks inside or outside.
// - Conversion lasts at least eight SAR clocks with busy high throughout.
// - Gain defaults to 0.5 after reset.
`timescale 1ns/10ps
module conv_ctrl (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire conv_ctrl_pkg::sfr_req_t  sfr_i,
    output logic      [7:0]               sfr_rdata_o,
    input  wire logic                     timer2_ovf_i,
    input  wire logic                     timer3_ovf_i,
    input  wire logic                     companion_busy_bit_i,
    input  wire logic                     ext_start_own_i,
    input  wire logic                     ext_start_companion_i,
    input  wire logic                     ext_start_own_routed_i,
    input  wire logic                     interrupt_enable_i,
    input  wire logic     [7:0]           sar_result_i,
    output conv_ctrl_pkg::mux_sel_t       mux_sel_o,
    output logic      [1:0]               gain_select_o,
    output logic                          shutdown_o,
    output logic                          track_o,
    output logic                          convert_o,
    output logic                          sar_clk_en_o,
    output logic                          irq_o
);
    typedef enum logic [1:0] {IDLE, TRACK, CONVERT} state_t;

    state_t     state;
    state_t     next_state;
    logic [3:0] pair_cfg;
    logic [2:0] channel_select_code;
    logic [4:0] sar_clock_divider;
    logic [1:0] gain_select;
    logic       converter_enable;
    logic       track_mode_select;
    logic       conversion_done_flag;
    logic [2:0] start_mode_select;
    logic       window_match_flag;
    logic [7:0] window_greater_limit;
    logic [7:0] window_less_limit;
    logic [7:0] data_word;
    logic [4:0] div_cnt;
    logic [3:0] phase_cnt;
    logic [3:0] next_phase_cnt;
    logic       ext_meta;
    logic       ext_sync;
    logic       ext_prev;
    logic       irq;

    // Decode
    wire wr_pair  = sfr_i.wr && sfr_i.addr == conv_ctrl_pkg::ADDR_INPUT_PAIR_CONFIG;
    wire wr_chan  = sfr_i.wr && sfr_i.addr == conv_ctrl_pkg::ADDR_CHANNEL_SELECT;
    wire wr_cfg   = sfr_i.wr && sfr_i.addr == conv_ctrl_pkg::ADDR_CONVERTER_CONFIG;
    wire wr_ctl   = sfr_i.wr && sfr_i.addr == conv_ctrl_pkg::ADDR_CONVERTER_CONTROL;
    wire wr_gt    = sfr_i.wr && sfr_i.addr == conv_ctrl_pkg::ADDR_WINDOW_GREATER;
    wire wr_lt    = sfr_i.wr && sfr_i.addr == conv_ctrl_pkg::ADDR_WINDOW_LESS;
    wire busy     = state != IDLE;
    wire sar_tick = div_cnt == sar_clock_divider;

    // Only the own start pin when routed, otherwise the companion pin
    wire ext_raw  = ext_start_own_routed_i ? ext_start_own_i
                                           : ext_start_companion_i;
    wire ext_rise = ext_sync && !ext_prev;

    // Trigger selection; writes of one to busy count only in software mode
    wire sw_start = wr_ctl && sfr_i.wdata[conv_ctrl_pkg::CTL_BUSY]
                    && start_mode_select == conv_ctrl_pkg::MODE_SOFTWARE;
    logic trigger;
    always_comb begin
        if (start_mode_select[2]) begin
            trigger = companion_busy_bit_i;
        end else begin
            case (start_mode_select[1:0])
                2'h0:    trigger = sw_start;
                2'h1:    trigger = timer3_ovf_i;
                2'h2:    trigger = ext_rise;
                2'h3:    trigger = timer2_ovf_i;
                default: trigger = 1'b0;
            endcase
        end
    end
    wire ext_mode = start_mode_select == conv_ctrl_pkg::MODE_EXTERNAL;
    // Starts accepted only when enabled and idle
    wire take     = trigger && converter_enable && !busy;
    wire lp_track = track_mode_select && !ext_mode;
    wire conv_end = state == CONVERT && sar_tick
                    && phase_cnt == conv_ctrl_pkg::CONVERT_SAR_CLOCKS - 4'h1;

    always_comb begin
        next_state     = state;
        next_phase_cnt = phase_cnt;
        case (state)
            IDLE: begin
                if (take) begin
                    next_state     = lp_track ? TRACK : CONVERT;
                    next_phase_cnt = 4'h0;
                end
            end
            TRACK: begin
                if (sar_tick) begin
                    next_phase_cnt = phase_cnt + 4'h1;
                    if (phase_cnt == {2'h0, conv_ctrl_pkg::TRACK_SAR_CLOCKS} - 4'h1) begin
                        next_state     = CONVERT;
                        next_phase_cnt = 4'h0;
                    end
                end
            end
            CONVERT: begin
                if (sar_tick) begin
                    next_phase_cnt = phase_cnt + 4'h1;
                end
                if (conv_end) begin
                    next_state = IDLE;
                end
            end
            default: next_state = IDLE;
        endcase
    end

    // Window: in-order limits flag inside, reversed limits flag outside
    wire diff_sel = mux_sel_o.differential;
    wire [7:0] res_b = sar_result_i ^ {diff_sel, 7'h00};
    wire [7:0] gt_b  = window_greater_limit ^ {diff_sel, 7'h00};
    wire [7:0] lt_b  = window_less_limit ^ {diff_sel, 7'h00};
    wire above_gt    = res_b > gt_b;
    wire below_lt    = res_b < lt_b;
    wire win_hit     = (lt_b > gt_b) ? (above_gt && below_lt)
                                     : (above_gt || below_lt);

    // Channel mux: pair bit of the selected pin decides differential mode; channel code bit 0 decides polarity
    wire pair_on = pair_cfg[channel_select_code[2:1]];
    wire [2:0] even_pin = {channel_select_code[2:1], 1'b0};
    wire [2:0] odd_pin  = {channel_select_code[2:1], 1'b1};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state     <= IDLE;
            phase_cnt <= 4'h0;
            div_cnt   <= 5'h00;
        end else begin
            state     <= next_state;
            phase_cnt <= next_phase_cnt;
            div_cnt   <= (sar_tick || !busy) ? 5'h00 : div_cnt + 5'h01;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= ext_raw;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pair_cfg            <= conv_ctrl_pkg::RST_INPUT_PAIR_CONFIG;
            channel_select_code <= conv_ctrl_pkg::RST_CHANNEL_SELECT;
            sar_clock_divider   <= conv_ctrl_pkg::RST_SAR_DIVIDER;
            gain_select         <= conv_ctrl_pkg::RST_GAIN;
        end else begin
            if (wr_pair) begin
                pair_cfg <= sfr_i.wdata[3:0];
            end
            if (wr_chan) begin
                channel_select_code <= sfr_i.wdata[2:0];
            end
            if (wr_cfg) begin
                sar_clock_divider <= sfr_i.wdata[conv_ctrl_pkg::CFG_DIV +: 5];
                gain_select       <= sfr_i.wdata[conv_ctrl_pkg::CFG_GAIN +: 2];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            converter_enable  <= conv_ctrl_pkg::RST_CONVERTER_CONTROL[conv_ctrl_pkg::CTL_ENABLE];
            track_mode_select <= conv_ctrl_pkg::RST_CONVERTER_CONTROL[conv_ctrl_pkg::CTL_TRACK];
            start_mode_select <=
                conv_ctrl_pkg::RST_CONVERTER_CONTROL[conv_ctrl_pkg::CTL_MODE +: 3];
        end else if (wr_ctl) begin
            converter_enable  <= sfr_i.wdata[conv_ctrl_pkg::CTL_ENABLE];
            track_mode_select <= sfr_i.wdata[conv_ctrl_pkg::CTL_TRACK];
            start_mode_select <= sfr_i.wdata[conv_ctrl_pkg::CTL_MODE +: 3];
        end
    end

    // Flags: a hardware set in the same cycle as a software clear wins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            conversion_done_flag <= conv_ctrl_pkg::RST_CONVERTER_CONTROL[conv_ctrl_pkg::CTL_DONE];
            window_match_flag    <=
                conv_ctrl_pkg::RST_CONVERTER_CONTROL[conv_ctrl_pkg::CTL_WINDOW];
            data_word            <= conv_ctrl_pkg::RST_DATA_WORD;
            irq                  <= 1'b0;
        end else begin
            if (conv_end) begin
                conversion_done_flag <= 1'b1;
                data_word            <= sar_result_i;
            end else if (wr_ctl) begin
                conversion_done_flag <= sfr_i.wdata[conv_ctrl_pkg::CTL_DONE];
            end
            if (conv_end && win_hit) begin
                window_match_flag <= 1'b1;
            end else if (wr_ctl) begin
                window_match_flag <= sfr_i.wdata[conv_ctrl_pkg::CTL_WINDOW];
            end
            irq <= conv_end && interrupt_enable_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            window_greater_limit <= conv_ctrl_pkg::RST_WINDOW_GREATER;
            window_less_limit    <= conv_ctrl_pkg::RST_WINDOW_LESS;
        end else begin
            if (wr_gt) begin
                window_greater_limit <= sfr_i.wdata;
            end
            if (wr_lt) begin
                window_less_limit <= sfr_i.wdata;
            end
        end
    end

    wire [7:0] ctl_rd = {converter_enable, track_mode_select, conversion_done_flag,
                         busy, start_mode_select, window_match_flag};
    logic [7:0] rdata;
    always_comb begin
        case (sfr_i.addr)
            conv_ctrl_pkg::ADDR_INPUT_PAIR_CONFIG: rdata = {4'h0, pair_cfg};
            conv_ctrl_pkg::ADDR_CHANNEL_SELECT:    rdata = {5'h00, channel_select_code};
            conv_ctrl_pkg::ADDR_CONVERTER_CONFIG:  rdata = {sar_clock_divider, 1'b0,
                                                            gain_select};
            conv_ctrl_pkg::ADDR_CONVERTER_CONTROL: rdata = ctl_rd;
            conv_ctrl_pkg::ADDR_WINDOW_GREATER:    rdata = window_greater_limit;
            conv_ctrl_pkg::ADDR_WINDOW_LESS:       rdata = window_less_limit;
            conv_ctrl_pkg::ADDR_DATA_WORD:         rdata = data_word;
            default:                               rdata = 8'h00;
        endcase
    end
    assign sfr_rdata_o = sfr_i.rd ? rdata : 8'h00;

    // Analog-side controls; track and convert timing comes from the state machine here
    always_comb begin
        mux_sel_o.valid        = converter_enable;
        mux_sel_o.differential = pair_on;
        if (pair_on) begin
            mux_sel_o.pos_pin = channel_select_code[0] ? odd_pin : even_pin;
            mux_sel_o.neg_pin = channel_select_code[0] ? even_pin : odd_pin;
        end else begin
            mux_sel_o.pos_pin = channel_select_code;
            mux_sel_o.neg_pin = 3'h0;
        end
    end
    assign gain_select_o = gain_select;
    assign shutdown_o    = !converter_enable;
    // Low-power external mode tracks only while the start pin is low
    assign track_o       = converter_enable && (state == TRACK
                           || (state == IDLE && !track_mode_select)
                           || (state == IDLE && track_mode_select && ext_mode
                               && !ext_sync));
    assign convert_o     = state == CONVERT;
    assign sar_clk_en_o  = busy && sar_tick;
    assign irq_o         = irq;
endmodule // conv_ctrl

// ===== sim/sar_core_model.sv
// Behavioural stand-in for the analog SAR core that feeds results back
`timescale 1ns/10ps
module sar_core_model (
    input  wire logic       clk_i,
    input  wire logic       convert_i,
    input  wire logic [7:0] value_i,
    output logic      [7:0] sar_result_o
);
    logic [7:0] last = 8'h5a;

    // Outside a conversion the result bus toggles so a stale value never looks valid
    always_ff @(posedge clk_i) begin
        last <= convert_i ? value_i : ~last;
    end
    assign sar_result_o = convert_i ? value_i : last;
endmodule // sar_core_model

// ===== sim/conv_ctrl_monitor.sv
// Assertion checker on the converter control ports
`timescale 1ns/10ps
module conv_ctrl_monitor (
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire conv_ctrl_pkg::sfr_req_t sfr_i,
    input wire logic [7:0]              sfr_rdata_o,
    input wire logic                    interrupt_enable_i,
    input wire conv_ctrl_pkg::mux_sel_t mux_sel_o,
    input wire logic [1:0]              gain_select_o,
    input wire logic                    track_o,
    input wire logic                    convert_o,
    input wire logic                    shutdown_o,
    input wire logic                    sar_clk_en_o,
    input wire logic                    irq_o
);
    logic [4:0] div;
    logic [3:0] pair;
    logic [2:0] chan;
    logic [5:0] gap;
    logic [5:0] conv_pulses;
    logic       prev_seen;
    wire        wr_cfg  = sfr_i.wr && sfr_i.addr == conv_ctrl_pkg::ADDR_CONVERTER_CONFIG;
    wire        wr_ctl  = sfr_i.wr && sfr_i.addr == conv_ctrl_pkg::ADDR_CONVERTER_CONTROL;
    wire        sel_dif = pair[chan[2:1]];

    // Shadow copies of the routing and divider fields, written like the real ones
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div  <= conv_ctrl_pkg::RST_SAR_DIVIDER;
            pair <= 4'h0;
            chan <= 3'h0;
        end else begin
            if (wr_cfg) div <= sfr_i.wdata[7:3];
            if (sfr_i.wr && sfr_i.addr == conv_ctrl_pkg::ADDR_INPUT_PAIR_CONFIG)
                pair <= sfr_i.wdata[3:0];
            if (sfr_i.wr && sfr_i.addr == conv_ctrl_pkg::ADDR_CHANNEL_SELECT)
                chan <= sfr_i.wdata[2:0];
        end
    end

    // First SAR clock of a conversion has no reference, so spacing starts at the second
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap         <= 6'h00;
            prev_seen   <= 1'b0;
            conv_pulses <= 6'h00;
        end else begin
            gap         <= sar_clk_en_o ? 6'h00 : gap + 6'h01;
            prev_seen   <= convert_o && (prev_seen || sar_clk_en_o);
            conv_pulses <= convert_o ? conv_pulses + 6'(sar_clk_en_o) : 6'h00;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_conv_end;
        convert_o ##1 !convert_o;
    endsequence

    property p_unused_zero;
        sfr_i.rd |->
            (sfr_i.addr != conv_ctrl_pkg::ADDR_INPUT_PAIR_CONFIG || sfr_rdata_o[7:4] == 4'h0)
            && (sfr_i.addr != conv_ctrl_pkg::ADDR_CHANNEL_SELECT || sfr_rdata_o[7:3] == 5'h00)
            && (sfr_i.addr != conv_ctrl_pkg::ADDR_CONVERTER_CONFIG || !sfr_rdata_o[2]);
    endproperty
    property p_mux_route;
        mux_sel_o.pos_pin == chan && mux_sel_o.differential == sel_dif
            && (!sel_dif || mux_sel_o.neg_pin == (chan ^ 3'h1));
    endproperty
    property p_sar_period;
        sar_clk_en_o && convert_o && prev_seen |-> gap == {1'b0, div};
    endproperty
    property p_gain;
        wr_cfg |=> gain_select_o == $past(sfr_i.wdata[1:0]);
    endproperty
    property p_shutdown;
        wr_ctl |=> shutdown_o == !$past(sfr_i.wdata[7]);
    endproperty
    property p_busy_read;
        sfr_i.rd && sfr_i.addr == conv_ctrl_pkg::ADDR_CONVERTER_CONTROL && convert_o |-> sfr_rdata_o[4];
    endproperty
    property p_irq;
        s_conv_end ##0 interrupt_enable_i |-> ##[0:1] irq_o;
    endproperty
    property p_conv_length;
        $fell(convert_o) |-> conv_pulses >= 6'h08;
    endproperty
    property p_track_exclusive;
        convert_o |-> !track_o;
    endproperty

    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bits read nonzero");
    a_mux_route: assert property (p_mux_route)
        else $error("mux routing wrong");
    a_sar_period: assert property (p_sar_period)
        else $error("SAR clock spacing wrong");
    a_gain: assert property (p_gain)
        else $error("gain not taken from write");
    a_shutdown: assert property (p_shutdown)
        else $error("shutdown not following enable");
    a_busy_read: assert property (p_busy_read)
        else $error("busy reads zero while converting");
    a_irq: assert property (p_irq)
        else $error("no interrupt after conversion");
    a_conv_length: assert property (p_conv_length)
        else $error("conversion too short");
    a_track_exclusive: assert property (p_track_exclusive)
        else $error("tracking while converting");
endmodule // conv_ctrl_monitor

bind conv_ctrl conv_ctrl_monitor u_monitor (.clk_i(clk_i), .rst_i(rst_i), .sfr_i(sfr_i),
    .sfr_rdata_o(sfr_rdata_o), .interrupt_enable_i(interrupt_enable_i), .mux_sel_o(mux_sel_o),
    .gain_select_o(gain_select_o), .track_o(track_o), .convert_o(convert_o),
    .shutdown_o(shutdown_o), .sar_clk_en_o(sar_clk_en_o), .irq_o(irq_o));

// ===== sim/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, timer2_ovf_i = 1'b0, timer3_ovf_i = 1'b0, irq_en = 1'b1;
    logic companion_busy_bit_i = 1'b0, ext_start_own_i = 1'b0, ext_start_companion_i = 1'b0;
    logic ext_start_own_routed_i = 1'b1, shutdown_o, track_o, convert_o, sar_clk_en_o, irq_o;
    conv_ctrl_pkg::sfr_req_t sfr_i = '0;
    conv_ctrl_pkg::mux_sel_t mux_sel_o;
    logic [7:0]  sfr_rdata_o, sar_result_i, q, ctl, e, value = 8'h00;
    logic [7:0]  ra[5] = '{8'hba, 8'hbb, 8'hbc, 8'hf8, 8'h00};
    logic [7:0]  rv[5] = '{8'h00, 8'h00, 8'hf8, 8'h00, 8'h00};
    logic [7:0]  rm[3] = '{8'h0f, 8'h07, 8'hfb};
    logic [2:0]  c, mode;
    logic [1:0]  gain_select_o;
    logic [31:0] seed = 32'd66;
    int          errors = 0, samples_checked = 0, pulses;
    int          exp_q[$];

    always #20 clk_i = ~clk_i;

    conv_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .sfr_i(sfr_i), .sfr_rdata_o(sfr_rdata_o),
        .timer2_ovf_i(timer2_ovf_i), .timer3_ovf_i(timer3_ovf_i),
        .companion_busy_bit_i(companion_busy_bit_i), .ext_start_own_i(ext_start_own_i),
        .ext_start_companion_i(ext_start_companion_i),
        .ext_start_own_routed_i(ext_start_own_routed_i),
        .interrupt_enable_i(irq_en), .sar_result_i(sar_result_i), .mux_sel_o(mux_sel_o),
        .gain_select_o(gain_select_o), .shutdown_o(shutdown_o), .track_o(track_o),
        .convert_o(convert_o), .sar_clk_en_o(sar_clk_en_o), .irq_o(irq_o));
    sar_core_model u_core (.clk_i(clk_i), .convert_i(convert_o), .value_i(value),
        .sar_result_o(sar_result_i));

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // One register cycle; read data is sampled mid-cycle where it has settled
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1 sfr_i = '{w, !w, a, d};
        @(negedge clk_i) q = sfr_rdata_o;
        @(posedge clk_i);
        #1 sfr_i = '0;
    endtask

    task automatic pulse(ref logic s);
        @(posedge clk_i);
        #1 s = 1'b1;
        @(posedge clk_i);
        #1 s = 1'b0;
    endtask

    // Bounded wait for convert level; counts SAR clocks seen while tracking
    task automatic wait_conv(input logic lvl);
        pulses = 0;
        for (int i = 0; i < 3000 && convert_o !== lvl; i++) begin
            @(negedge clk_i);
            pulses += int'(track_o === 1'b1 && sar_clk_en_o === 1'b1);
        end
        if (convert_o !== lvl) begin
            check(8'(convert_o), 8'(lvl), "wait for conversion timed out");
            report_and_stop();
        end
    endtask

    task automatic quiet();
        repeat (8) begin
            @(negedge clk_i);
            check(8'(convert_o), 8'h00, "unexpected conversion start");
        end
    endtask

    task automatic fire(input int k);
        case (k)
            0: bus(1'b1, conv_ctrl_pkg::ADDR_CONVERTER_CONTROL, ctl | 8'h10);
            1: pulse(timer3_ovf_i);
            2: begin @(posedge clk_i); #1 ext_start_own_i = 1'b1; end
            3: pulse(timer2_ovf_i);
            4: pulse(companion_busy_bit_i);
            default: begin @(posedge clk_i); #1 ext_start_companion_i = 1'b1; end
        endcase
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        #1 rst_i = 1'b0;
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, ra[i], 8'h00);
            check(q, rv[i], "reset value");
        end
        check(8'(gain_select_o), 8'h00, "gain after reset");
        check(8'(shutdown_o), 8'h01, "shutdown after reset");
        $display("test reset_values finished");
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, ra[i], 8'hff);
            bus(1'b0, ra[i], 8'h00);
            check(q, rm[i], "unused bits");
        end
        for (int g = 0; g < 4; g++) begin
            bus(1'b1, conv_ctrl_pkg::ADDR_CONVERTER_CONFIG, {5'h01, 1'b0, 2'(g)});
            check(8'(gain_select_o), 8'(g), "gain select");
        end
        for (int i = 0; i < 16; i++) begin
            value = xorshift();
            c = 3'(i);
            bus(1'b1, conv_ctrl_pkg::ADDR_INPUT_PAIR_CONFIG, {4'h0, value[3:0]});
            bus(1'b1, conv_ctrl_pkg::ADDR_CHANNEL_SELECT, {5'h00, c});
            check(8'(mux_sel_o.pos_pin), 8'(c), "positive pin");
            check(8'(mux_sel_o.differential), 8'(value[c[2:1]]), "pair mode");
            if (value[c[2:1]])
                check(8'(mux_sel_o.neg_pin), 8'(c ^ 3'h1), "negative pin");
        end
        $display("test routing finished");
        bus(1'b1, conv_ctrl_pkg::ADDR_INPUT_PAIR_CONFIG, 8'h00);
        bus(1'b1, conv_ctrl_pkg::ADDR_WINDOW_GREATER, 8'h10);
        bus(1'b1, conv_ctrl_pkg::ADDR_WINDOW_LESS, 8'h20);
        for (int tm = 0; tm < 2; tm++) begin
            for (int k = 0; k < 6; k++) begin
                mode = (k == 5) ? 3'h2 : ((k == 4) ? 3'h4 : 3'(k));
                ctl = {1'b1, 1'(tm), 2'b00, mode, 1'b0};
                ext_start_own_routed_i = (k != 5);
                irq_en = (k != 3);
                bus(1'b1, conv_ctrl_pkg::ADDR_CONVERTER_CONTROL, ctl);
                value = xorshift();
                value = 8'h0f + (value & 8'h1f);
                exp_q.push_back(int'(value));
                if (k == 2) ext_start_companion_i = 1'b1;
                if (k != 0) bus(1'b1, conv_ctrl_pkg::ADDR_CONVERTER_CONTROL, ctl | 8'h10);
                if (k != 0) quiet();
                check(8'(track_o), 8'(!(tm == 1 && mode != 3'h2)),
                      "idle tracking");
                fire(k);
                wait_conv(1'b1);
                if (tm == 1 && mode != 3'h2)
                    check(8'(pulses), 8'h03, "tracking SAR clocks");
                if (k != 2 && k != 5) fire(k);
                wait_conv(1'b0);
                check(8'(irq_o), 8'(irq_en), "interrupt pulse");
                quiet();
                e = 8'(exp_q.pop_front());
                bus(1'b0, conv_ctrl_pkg::ADDR_CONVERTER_CONTROL, 8'h00);
                check(q, ctl | 8'h20 | 8'(e > 8'h10 && e < 8'h20),
                      "status after conversion");
                bus(1'b0, conv_ctrl_pkg::ADDR_DATA_WORD, 8'h00);
                check(q, e, "conversion result");
                ext_start_own_i = 1'b0;
                ext_start_companion_i = 1'b0;
                bus(1'b1, conv_ctrl_pkg::ADDR_CONVERTER_CONTROL, ctl);
            end
        end
        $display("test conversions finished");
        report_and_stop();
    end
endmodule // tb_top
